/* logic/mfp_pkg.sv */
// Purpose: Constants and types for the multi-function port mapper.
// Assumes: One core clock; the port strobe is sampled as a synchronous input.
// Notes: Select codes pair a direction bit with a five-bit function index.
// How it works
// - Eight select registers at 0x0F to 0x16.
// - Outputs drive status; inputs set control bits.
// - Select bit 5 set means pin input.
// - Select bits 4:0 choose the function.
// - Data phase strobe stores into addressed register.
// - Codes 01 to 1F map status outputs.
// - Codes 20 to 2F map control inputs.
// - Reset restores default pin mapping, all outputs.
// - Port bus carries ancillary out, control in.
// - Rising edge of the sampled host strobe marks each control write.
package mfp_pkg;
   localparam int NUM_PINS = 8;
   localparam int SEL_W = 6;
   localparam int BUS_W = 10;
   localparam int DIR_BIT = 5;
   localparam logic [BUS_W-1:0] PIN_SEL_BASE = 10'h00F;
   localparam logic [BUS_W-1:0] PIN_SEL_LAST = 10'h016;
   localparam logic [SEL_W-1:0] SEL_RESET [NUM_PINS] = '{6'h12, 6'h13, 6'h14, 6'h19,
                                                        6'h1C, 6'h04, 6'h1B, 6'h0E};

   typedef enum logic [0:0]
   {
      PH_ADDR = 1'b0,
      PH_DATA = 1'b1
   } mfp_phase_t;

   typedef struct packed
   {
      logic edh_force;
      logic [5:0] test_pattern_select;
      logic edh_enable;
      logic pattern_generator_enable;
      logic pattern_filter_enable;
      logic dedither_enable;
      logic framing_enable;
      logic fifo_extract_enable;
   } mfp_ctrl_t;

   typedef struct packed
   {
      logic [BUS_W-1:0] data;
      logic port_function_select;
      logic rd_wr;
      logic strobe;
   } mfp_port_t;
endpackage : mfp_pkg

/* logic/mfp_pin_route.sv */
// Purpose: Routes one port pin according to its select code.
// Assumes: Status vector index equals the five-bit code.
// Notes: Reserved codes leave the pin undriven and steer nothing.
`timescale 1ns/10ps
module mfp_pin_route
(
   input wire logic [mfp_pkg::SEL_W-1:0] sel,
   input wire logic [31:0] status_vec,
   output logic pin_oe,
   output logic pin_val,
   output logic [31:0] ctrl_hit
);
   function automatic logic code_reserved(input logic [mfp_pkg::SEL_W-1:0] c);
      code_reserved = (c == 6'h00) || (c == 6'h05) || (c == 6'h06) ||
                      (c >= 6'h0A && c <= 6'h0C) || (c >= 6'h29 && c <= 6'h2B) ||
                      (c >= 6'h30);
   endfunction : code_reserved

   always_comb
   begin
      pin_oe = 1'b0;
      pin_val = 1'b0;
      ctrl_hit = 32'h0000_0000;
      if (!code_reserved(sel))
      begin
         if (sel[mfp_pkg::DIR_BIT])
         begin
            ctrl_hit[sel[4:0]] = 1'b1;
         end
         else
         begin
            pin_oe = 1'b1;
            pin_val = status_vec[sel[4:0]];
         end
      end
   end
endmodule : mfp_pin_route

/* logic/mfp_port_mapper.sv */
// Purpose: Multi-function I/O port mapper with its select registers.
// Assumes: Port signals are synchronous to mclk; the strobe is a level sampled here.
// Notes: A strobe is one rising edge of the sampled port strobe.
`timescale 1ns/10ps
module mfp_port_mapper
(
   input wire logic mclk,
   input wire logic rst_b,
   input wire mfp_pkg::mfp_port_t port_in,
   input wire logic [9:0] anc_data,
   output logic [9:0] port_data_out,
   output logic port_data_oe,
   input wire logic [31:0] status_vec,
   input wire logic [7:0] io_pin_in,
   output logic [7:0] io_pin_out,
   output logic [7:0] io_pin_oe,
   output mfp_pkg::mfp_ctrl_t ctrl_out
);
   logic strobe_reg;
   logic strobe_rise;
   logic ctrl_wr;
   mfp_pkg::mfp_phase_t phase_reg;
   logic [mfp_pkg::BUS_W-1:0] addr_reg;
   logic [mfp_pkg::SEL_W-1:0] sel_reg [mfp_pkg::NUM_PINS];
   logic [7:0] oe_w;
   logic [7:0] val_w;
   logic [31:0] hit_w [mfp_pkg::NUM_PINS];
   logic [31:0] ctrl_vec_reg;
   logic [31:0] ctrl_vec_next;
   logic [9:0] anc_reg;
   logic [7:0] dir_w;

   assign strobe_rise = port_in.strobe && !strobe_reg;
   assign ctrl_wr = strobe_rise && !port_in.port_function_select && !port_in.rd_wr;

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         strobe_reg <= 1'b0;
      else
         strobe_reg <= port_in.strobe;
   end

   // Address phase then data phase on the control path.
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         phase_reg <= mfp_pkg::PH_ADDR;
         addr_reg <= 10'h000;
      end
      else if (ctrl_wr)
      begin
         case (phase_reg)
            mfp_pkg::PH_ADDR:
            begin
               addr_reg <= port_in.data;
               phase_reg <= mfp_pkg::PH_DATA;
            end
            mfp_pkg::PH_DATA:
            begin
               phase_reg <= mfp_pkg::PH_ADDR;
            end
            default:
            begin
               phase_reg <= mfp_pkg::PH_ADDR;
            end
         endcase
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < mfp_pkg::NUM_PINS; gi++)
      begin : g_pin
         always_ff @(posedge mclk)
         begin
            if (!rst_b)
               sel_reg[gi] <= mfp_pkg::SEL_RESET[gi];
            else if (ctrl_wr && phase_reg == mfp_pkg::PH_DATA &&
                     addr_reg == mfp_pkg::PIN_SEL_BASE + 10'(gi))
               sel_reg[gi] <= port_in.data[mfp_pkg::SEL_W-1:0];
         end

         mfp_pin_route u_route
         (
            .sel(sel_reg[gi]),
            .status_vec(status_vec),
            .pin_oe(oe_w[gi]),
            .pin_val(val_w[gi]),
            .ctrl_hit(hit_w[gi])
         );
      end
   endgenerate

   // Highest-numbered pin wins when two pins map the same control bit.
   always_comb
   begin
      ctrl_vec_next = ctrl_vec_reg;
      for (int p = 0; p < mfp_pkg::NUM_PINS; p++)
      begin
         for (int b = 0; b < 32; b++)
         begin
            if (hit_w[p][b])
               ctrl_vec_next[b] = io_pin_in[p];
         end
      end
   end

   always_ff @(posedge mclk)
   begin
      if (!rst_b)
      begin
         ctrl_vec_reg <= 32'h0000_0000;
         io_pin_out <= 8'h00;
      end
      else
      begin
         ctrl_vec_reg <= ctrl_vec_next;
         io_pin_out <= val_w;
      end
   end

   assign io_pin_oe = oe_w;

   always_comb
   begin
      ctrl_out.edh_force = ctrl_vec_reg[0];
      ctrl_out.test_pattern_select = ctrl_vec_reg[6:1];
      ctrl_out.edh_enable = ctrl_vec_reg[7];
      ctrl_out.pattern_generator_enable = ctrl_vec_reg[8];
      ctrl_out.pattern_filter_enable = ctrl_vec_reg[12];
      ctrl_out.dedither_enable = ctrl_vec_reg[13];
      ctrl_out.framing_enable = ctrl_vec_reg[14];
      ctrl_out.fifo_extract_enable = ctrl_vec_reg[15];
   end

   // Ancillary path drives the bus on reads with the function select high.
   always_ff @(posedge mclk)
   begin
      if (!rst_b)
         anc_reg <= 10'h000;
      else
         anc_reg <= anc_data;
   end

   assign port_data_out = anc_reg;
   assign port_data_oe = port_in.port_function_select && port_in.rd_wr;

   property p_addr_then_data;
      @(posedge mclk) disable iff (!rst_b)
      (ctrl_wr && phase_reg == mfp_pkg::PH_ADDR) |=> (phase_reg == mfp_pkg::PH_DATA);
   endproperty
   a_addr_then_data: assert property (p_addr_then_data) else $error("no data phase");

   property p_pin0_store;
      @(posedge mclk) disable iff (!rst_b)
      (ctrl_wr && phase_reg == mfp_pkg::PH_DATA && addr_reg == mfp_pkg::PIN_SEL_BASE)
      |=> (sel_reg[0] == $past(port_in.data[5:0]));
   endproperty
   a_pin0_store: assert property (p_pin0_store) else $error("pin0 not stored");

   property p_pin7_store;
      @(posedge mclk) disable iff (!rst_b)
      (ctrl_wr && phase_reg == mfp_pkg::PH_DATA && addr_reg == mfp_pkg::PIN_SEL_LAST)
      |=> (sel_reg[7] == $past(port_in.data[5:0]));
   endproperty
   a_pin7_store: assert property (p_pin7_store) else $error("pin7 not stored");

   property p_input_no_drive;
      @(posedge mclk) disable iff (!rst_b)
      sel_reg[0][mfp_pkg::DIR_BIT] |-> !io_pin_oe[0];
   endproperty
   a_input_no_drive: assert property (p_input_no_drive) else $error("input driven");

   property p_out_follows;
      @(posedge mclk) disable iff (!rst_b)
      (io_pin_oe[1] && $stable(sel_reg[1])) |=> (io_pin_out[1] == $past(status_vec[sel_reg[1][4:0]]));
   endproperty
   a_out_follows: assert property (p_out_follows) else $error("output wrong");

   property p_reset_map;
      @(posedge mclk)
      !rst_b |=> (sel_reg[0] == 6'h12 && sel_reg[3] == 6'h19 && sel_reg[7] == 6'h0E);
   endproperty
   a_reset_map: assert property (p_reset_map) else $error("bad default map");

   property p_framing_in;
      @(posedge mclk) disable iff (!rst_b)
      (sel_reg[2] == 6'h2E && sel_reg[3] != 6'h2E && sel_reg[4] != 6'h2E &&
       sel_reg[5] != 6'h2E && sel_reg[6] != 6'h2E && sel_reg[7] != 6'h2E)
      |=> (ctrl_out.framing_enable == $past(io_pin_in[2]));
   endproperty
   a_framing_in: assert property (p_framing_in) else $error("input not taken");

   property p_reserved_quiet;
      @(posedge mclk) disable iff (!rst_b)
      (sel_reg[5] == 6'h05) |-> !io_pin_oe[5];
   endproperty
   a_reserved_quiet: assert property (p_reserved_quiet) else $error("reserved drives");

   property p_status_out;
      @(posedge mclk) disable iff (!rst_b)
      (sel_reg[6] == 6'h0F) |-> io_pin_oe[6];
   endproperty
   a_status_out: assert property (p_status_out) else $error("status not out");

   // A control write is two strobes: the address first, then the data.
   sequence s_addr_strobe;
      ctrl_wr && phase_reg == mfp_pkg::PH_ADDR;
   endsequence

   sequence s_data_strobe;
      ctrl_wr && phase_reg == mfp_pkg::PH_DATA;
   endsequence

   sequence s_pin3_data;
      s_data_strobe ##0 (addr_reg == mfp_pkg::PIN_SEL_BASE + 10'h003);
   endsequence

   sequence s_outside_data;
      s_data_strobe ##0 (addr_reg < mfp_pkg::PIN_SEL_BASE || addr_reg > mfp_pkg::PIN_SEL_LAST);
   endsequence

   property p_addr_holds;
      @(posedge mclk) disable iff (!rst_b)
      s_addr_strobe |=> (addr_reg == $past(port_in.data));
   endproperty
   a_addr_holds: assert property (p_addr_holds) else $error("address not held");

   property p_data_back_to_addr;
      @(posedge mclk) disable iff (!rst_b)
      s_data_strobe |=> (phase_reg == mfp_pkg::PH_ADDR);
   endproperty
   a_data_back_to_addr: assert property (p_data_back_to_addr) else $error("phase stuck");

   property p_pin3_store;
      @(posedge mclk) disable iff (!rst_b)
      s_pin3_data |=> (sel_reg[3] == $past(port_in.data[5:0]));
   endproperty
   a_pin3_store: assert property (p_pin3_store) else $error("pin3 not stored");

   property p_outside_no_store;
      @(posedge mclk) disable iff (!rst_b)
      s_outside_data |=> ($stable(sel_reg[0]) && $stable(sel_reg[7]));
   endproperty
   a_outside_no_store: assert property (p_outside_no_store) else $error("stray store");

   property p_refused_strobe;
      @(posedge mclk) disable iff (!rst_b)
      (strobe_rise && (port_in.port_function_select || port_in.rd_wr))
      |=> ($stable(phase_reg) && $stable(sel_reg[0]));
   endproperty
   a_refused_strobe: assert property (p_refused_strobe) else $error("refused strobe taken");

   property p_anc_oe;
      @(posedge mclk) disable iff (!rst_b)
      (port_in.port_function_select && port_in.rd_wr) |-> port_data_oe;
   endproperty
   a_anc_oe: assert property (p_anc_oe) else $error("ancillary not driven");

   property p_anc_delay;
      @(posedge mclk) disable iff (!rst_b)
      $past(rst_b) |-> (port_data_out == $past(anc_data));
   endproperty
   a_anc_delay: assert property (p_anc_delay) else $error("ancillary word wrong");

   property p_reset_outputs;
      @(posedge mclk)
      !rst_b |=> (io_pin_oe == 8'hFF && io_pin_out == 8'h00 && ctrl_vec_reg == 32'h0000_0000);
   endproperty
   a_reset_outputs: assert property (p_reset_outputs) else $error("bad reset outputs");

   property p_ctrl_hold;
      @(posedge mclk) disable iff (!rst_b)
      (dir_w == 8'h00) |=> $stable(ctrl_vec_reg);
   endproperty
   a_ctrl_hold: assert property (p_ctrl_hold) else $error("control bit moved");

   property p_edh_force_in;
      @(posedge mclk) disable iff (!rst_b)
      (sel_reg[0] == 6'h20 && dir_w[7:1] == 7'h00)
      |=> (ctrl_out.edh_force == $past(io_pin_in[0]));
   endproperty
   a_edh_force_in: assert property (p_edh_force_in) else $error("force not taken");

   // Per-pin checks of direction and output value.
   generate
      for (gi = 0; gi < mfp_pkg::NUM_PINS; gi++)
      begin : g_pin_chk
         assign dir_w[gi] = sel_reg[gi][mfp_pkg::DIR_BIT];

         property p_dir_in_quiet;
            @(posedge mclk) disable iff (!rst_b)
            dir_w[gi] |-> !io_pin_oe[gi];
         endproperty
         a_dir_in_quiet: assert property (p_dir_in_quiet) else $error("input pin driven");

         property p_pin_value;
            @(posedge mclk) disable iff (!rst_b)
            (io_pin_oe[gi] && $stable(sel_reg[gi]))
            |=> (io_pin_out[gi] == $past(status_vec[sel_reg[gi][4:0]]));
         endproperty
         a_pin_value: assert property (p_pin_value) else $error("pin value wrong");
      end
   endgenerate
endmodule : mfp_port_mapper

/* sim/mfp_host_model.sv */
// Purpose: Host model that writes pin select registers over the port.
// Assumes: Drives just after the falling edge; one strobe per word.
// Notes: Strobe idles low; a released data bus shows the inverted word.
`timescale 1ns/10ps
module mfp_host_model
(
   input wire logic mclk,
   output mfp_pkg::mfp_port_t port
);
   initial port = '0;

   task automatic send(input logic [9:0] w, input logic fs, input logic rw);
      @(negedge mclk);
      port.data = w;
      port.port_function_select = fs;
      port.rd_wr = rw;
      port.strobe = 1'b1;
      @(negedge mclk);
      port.strobe = 1'b0;
      @(negedge mclk);
      port.data = ~w;
   endtask : send

   // Callers keep the direction bit matched to the code class.
   task automatic write_reg(input logic [9:0] a, input logic [9:0] d, input logic fs,
                            input logic rw);
      send(a, fs, rw);
      send(d, fs, rw);
   endtask : write_reg
endmodule : mfp_host_model

/* sim/mfp_port_mapper_tb.sv */
// Purpose: Self-checking bench for the port mapper.
// Assumes: Inputs change at the falling edge of mclk.
// Notes: Each scenario task drives and judges before it returns.
`timescale 1ns/10ps
module mfp_port_mapper_tb;
   logic mclk;
   logic rst_b;
   logic [9:0] anc_data;
   logic [31:0] status_vec;
   logic [7:0] io_pin_in;
   logic [9:0] port_data_out;
   logic port_data_oe;
   logic [7:0] io_pin_out;
   logic [7:0] io_pin_oe;
   mfp_pkg::mfp_ctrl_t ctrl_out;
   mfp_pkg::mfp_port_t port_in;
   int n_errors = 0;
   int check_count = 0;
   logic [5:0] dflt [8] = '{6'h12, 6'h13, 6'h14, 6'h19, 6'h1C, 6'h04, 6'h1B, 6'h0E};

   mfp_host_model i_host (.mclk(mclk), .port(port_in));
   mfp_port_mapper i_dut (.mclk(mclk), .rst_b(rst_b), .port_in(port_in),
      .anc_data(anc_data), .port_data_out(port_data_out), .port_data_oe(port_data_oe),
      .status_vec(status_vec), .io_pin_in(io_pin_in), .io_pin_out(io_pin_out),
      .io_pin_oe(io_pin_oe), .ctrl_out(ctrl_out));

   initial
   begin
      mclk = 1'b0;
      forever #10 mclk = ~mclk;
   end

   function automatic logic is_rsv(input logic [5:0] c);
      return c inside {6'h00, 6'h05, 6'h06, 6'h0A, 6'h0B, 6'h0C, 6'h29, 6'h2A, 6'h2B};
   endfunction : is_rsv

   function automatic int ctl_idx(input int c);
      if (c == 32)
         return 12;
      if (c <= 38)
         return c - 27;
      if (c <= 40)
         return 44 - c;
      return 47 - c;
   endfunction : ctl_idx

   task automatic tick(input int n);
      repeat (n) @(negedge mclk);
   endtask : tick

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp)
      begin
         n_errors++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic pin_check(input int p, input logic [5:0] c);
      logic out_ok;
      out_ok = !c[5] && !is_rsv(c);
      for (int k = 0; k < 2; k++)
      begin
         status_vec = k ? 32'h5A3C_690F : 32'hA5C3_96F0;
         tick(2);
         check("pin_oe", io_pin_oe[p], out_ok);
         if (out_ok)
            check("pin_out", io_pin_out[p], status_vec[c[4:0]]);
      end
   endtask : pin_check

   task automatic t_defaults;
      check("ctrl_rst", ctrl_out, 13'h0000);
      for (int p = 0; p < 8; p++)
         pin_check(p, dflt[p]);
      $display("test defaults done");
   endtask : t_defaults

   task automatic t_out_codes;
      for (int c = 0; c < 32; c++)
      begin
         i_host.write_reg(10'h016, {4'hC, 6'(c)}, 1'b0, 1'b0);
         pin_check(7, 6'(c));
      end
      $display("test output codes done");
   endtask : t_out_codes

   task automatic t_in_codes;
      logic [12:0] held;
      for (int c = 32; c < 48; c++)
      begin
         i_host.write_reg(10'h011, 10'(c), 1'b0, 1'b0);
         for (int v = 1; v >= 0; v--)
         begin
            held = ctrl_out;
            io_pin_in[2] = v[0];
            tick(2);
            check("pin_in_oe", io_pin_oe[2], 1'b0);
            if (is_rsv(6'(c)))
               check("ctrl_hold", ctrl_out, held);
            else
               check("ctrl_bit", ctrl_out[ctl_idx(c)], v[0]);
         end
      end
      $display("test input codes done");
   endtask : t_in_codes

   task automatic t_all_pins;
      for (int p = 0; p < 8; p++)
         i_host.write_reg(10'h00F + 10'(p), 10'h015 + 10'(p), 1'b0, 1'b0);
      for (int p = 0; p < 8; p++)
         pin_check(p, 6'h15 + 6'(p));
      $display("test all pins done");
   endtask : t_all_pins

   task automatic t_refused;
      i_host.write_reg(10'h00F, 10'h02C, 1'b1, 1'b1);
      check("anc_oe", port_data_oe, 1'b1);
      check("anc_data", port_data_out, anc_data);
      i_host.write_reg(10'h00F, 10'h02C, 1'b0, 1'b1);
      i_host.write_reg(10'h00E, 10'h02C, 1'b0, 1'b0);
      i_host.write_reg(10'h017, 10'h02C, 1'b0, 1'b0);
      check("anc_oe_off", port_data_oe, 1'b0);
      pin_check(0, 6'h15);
      i_host.write_reg(10'h00F, 10'h310, 1'b0, 1'b0);
      pin_check(0, 6'h10);
      $display("test refused done");
   endtask : t_refused

   task automatic t_quiet;
      i_host.write_reg(10'h00F, 10'h020, 1'b0, 1'b0);
      i_host.write_reg(10'h014, 10'h005, 1'b0, 1'b0);
      i_host.write_reg(10'h015, 10'h00F, 1'b0, 1'b0);
      pin_check(5, 6'h05);
      pin_check(6, 6'h0F);
      for (int v = 1; v >= 0; v--)
      begin
         io_pin_in[0] = v[0];
         tick(2);
         check("edh_force", ctrl_out.edh_force, v[0]);
         check("pin0_oe", io_pin_oe[0], 1'b0);
      end
      $display("test quiet codes done");
   endtask : t_quiet

   task automatic close_out;
      $display("checks %0d mismatches %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : close_out

   initial
   begin
      repeat (6000) @(posedge mclk);
      n_errors++;
      close_out();
   end

   initial
   begin
      rst_b = 1'b0;
      anc_data = 10'h2A5;
      status_vec = 32'h0;
      io_pin_in = 8'h00;
      tick(8);
      rst_b = 1'b1;
      tick(1);
      t_defaults();
      t_out_codes();
      t_in_codes();
      t_all_pins();
      t_refused();
      t_quiet();
      rst_b = 1'b0;
      tick(8);
      rst_b = 1'b1;
      tick(1);
      t_defaults();
      close_out();
   end
endmodule : mfp_port_mapper_tb
